// file: src/dfcr_pkg.sv
// Constants for the DSP feature control register group.
// Assumes 16-bit registers at even byte offsets on the control link.
package dfcr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [6:0] DFCR_OFS_EQ     = 7'h70; // Equaliser and surround
    localparam logic [6:0] DFCR_OFS_BASS   = 7'h72; // Bass management
    localparam logic [6:0] DFCR_OFS_BYPASS = 7'h74; // Whole-DSP bypass
    localparam logic [6:0] DFCR_OFS_STATUS = 7'h76; // Self-test and lock status
    localparam logic [6:0] DFCR_OFS_COEF_L = 7'h78; // Coefficient bits 15..0
    localparam logic [6:0] DFCR_OFS_COEF_H = 7'h7A; // Address, direction, bits 19..16
    localparam logic [6:0] DFCR_OFS_VID_0  = 7'h7C; // Vendor code upper word
    localparam logic [6:0] DFCR_OFS_VID_1  = 7'h7E; // Vendor code byte and revision

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int DFCR_EQ_STATIC_BIT   = 0;  // Static equalisation
    localparam int DFCR_EQ_SURROUND_BIT = 1;  // Side-firing surround plus EQ
    localparam int DFCR_BASS_EN_BIT     = 0;  // Bass management enable
    localparam int DFCR_BYPASS_BIT      = 0;  // DSP bypass
    localparam int DFCR_STS_RESAMP_BIT  = 0;  // Resampler out of lock
    localparam int DFCR_STS_SPDIF_BIT   = 1;  // Receiver out of lock
    localparam int DFCR_STS_CFRAME_BIT  = 10; // Compressed-frame automute enable
    localparam int DFCR_STS_CHSTAT_BIT  = 11; // Channel-status automute enable
    localparam int DFCR_CH_ADDR_LSB     = 8;  // Coefficient address field
    localparam int DFCR_CH_DIR_BIT      = 7;  // Transfer direction
    localparam int DFCR_CH_VAL_MSB      = 3;  // Top coefficient nibble

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [1:0]  DFCR_RST_EQ     = 2'h0;
    localparam logic        DFCR_RST_BASS   = 1'b0;
    localparam logic        DFCR_RST_BYPASS = 1'b0;
    localparam logic        DFCR_RST_UNLOCK = 1'b1; // Both loops read unlocked
    localparam logic        DFCR_RST_CFRAME = 1'b1;
    localparam logic        DFCR_RST_CHSTAT = 1'b0;
    localparam logic [19:0] DFCR_RST_COEF   = 20'h00000;
    localparam logic [7:0]  DFCR_RST_CADDR  = 8'h00;
    localparam logic [15:0] DFCR_RD_ZERO    = 16'h0000;

endpackage

// file: src/dfcr_sync2.sv
// Two-flop synchroniser for levels arriving from outside the clock domain.
// Assumes the inputs are quasi-static levels; reset forces a constant.
`timescale 1ns/100ps
module dfcr_sync2 #(
    parameter int          WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // Levels in and out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage_one;       // Metastable stage, read only below
    logic [WIDTH-1:0] next_stage_one;  // Next first stage
    logic [WIDTH-1:0] next_sync;       // Next second stage

    ////////////////////////////////////////////////////////////////////////////
    // Next values
    always_comb begin
        next_stage_one = async_i;
        next_sync      = stage_one;
    end

    // Registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stage_one <= RESET_VAL;
            sync_o    <= RESET_VAL;
        end else begin
            stage_one <= next_stage_one;
            sync_o    <= next_sync;
        end
    end

endmodule

// file: src/dfcr_regs.sv
// DSP feature control and status register group, 16-bit registers at 70h..7Eh.
// Assumes a host-side link controller that issues one-cycle read and write strobes.
//
// Operation
// - Two-bit EQ mode; upper bit means surround
// - Bit 0 enables bass management, resets off
// - Bypass passes input through, overrides EQ, surround and bass; automute enables unaffected
// - Status bit 0 shows resampler unlock, resets one
// - Status bit 1 shows receiver unlock, resets one
// - Bit 10 compressed-frame automute enable, resets one
// - Bit 11 channel-status automute enable, resets zero
// - Two coefficient words: value, address, direction
// - Identification words read-only, writes discarded
// - Vendor code constant across both words
// - Low byte of second word is revision
`timescale 1ns/100ps
module dfcr_regs
    import dfcr_pkg::*;
#(
    parameter logic [15:0] VENDOR_CODE_HI  = 16'h1234, // Arbitrary value
    parameter logic [7:0]  VENDOR_CODE_LO  = 8'h56,    // Arbitrary value
    parameter logic [7:0]  VENDOR_REVISION = 8'h01     // Arbitrary value
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Register port from the control link
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [6:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    output logic             reg_rvalid_o,
    // Lock levels from other clock domains
    input  wire logic        resampler_unlock_i,
    input  wire logic        spdif_unlock_i,
    // Processing controls
    output logic             eq_surround_control_enable_o,
    output logic             surround_eq_select_o,
    output logic             bass_manage_en_o,
    output logic             dsp_bypass_o,
    output logic             compressed_frame_automute_en_o,
    output logic             chan_status_automute_en_o,
    // Coefficient transfer request
    output logic [19:0]      coef_value_o,
    output logic [7:0]       coef_address_o,
    output logic             coef_write_o,
    output logic             coef_xfer_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic       rst_meta;           // First reset stage
    logic       rst_b;              // Released reset used everywhere

    // Reset asserts at once, releases after two edges
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta <= 1'b0;
            rst_b    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_b    <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock status synchronisers
    logic [1:0] unlock_sync;        // Resampler in bit 0, receiver in bit 1

    // Both read out of lock until the loops report otherwise
    dfcr_sync2 #(
        .WIDTH     (2),
        .RESET_VAL ({DFCR_RST_UNLOCK, DFCR_RST_UNLOCK})
    ) u_lock_sync (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b),
        .async_i   ({spdif_unlock_i, resampler_unlock_i}),
        .sync_o    (unlock_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode helper
    function automatic logic hit(input logic [6:0] addr, input logic [6:0] ofs);
        hit = (addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Control state
    logic [1:0]  eq_mode;           // Equaliser mode field
    logic        bass_en;           // Bass management bit
    logic        bypass;            // Bypass bit
    logic        cframe_mute_en;    // Compressed-frame automute enable
    logic        chstat_mute_en;    // Channel-status automute enable
    logic [15:0] coef_low;          // Coefficient bits 15..0
    logic [3:0]  coef_high;         // Coefficient bits 19..16
    logic [7:0]  coef_addr;         // Coefficient address
    logic        coef_dir;          // Direction flag
    logic        xfer;              // Transfer strobe
    logic [1:0]  next_eq_mode;
    logic        next_bass_en;
    logic        next_bypass;
    logic        next_cframe_mute_en;
    logic        next_chstat_mute_en;
    logic [15:0] next_coef_low;
    logic [3:0]  next_coef_high;
    logic [7:0]  next_coef_addr;
    logic        next_coef_dir;
    logic        next_xfer;

    // Write decode; unlisted offsets and read-only words change nothing
    always_comb begin
        next_eq_mode        = eq_mode;
        next_bass_en        = bass_en;
        next_bypass         = bypass;
        next_cframe_mute_en = cframe_mute_en;
        next_chstat_mute_en = chstat_mute_en;
        next_coef_low       = coef_low;
        next_coef_high      = coef_high;
        next_coef_addr      = coef_addr;
        next_coef_dir       = coef_dir;
        next_xfer           = 1'b0;
        if (reg_wr_i) begin
            if (hit(reg_addr_i, DFCR_OFS_EQ)) begin
                next_eq_mode = reg_wdata_i[DFCR_EQ_SURROUND_BIT:DFCR_EQ_STATIC_BIT];
            end
            if (hit(reg_addr_i, DFCR_OFS_BASS)) begin
                next_bass_en = reg_wdata_i[DFCR_BASS_EN_BIT];
            end
            if (hit(reg_addr_i, DFCR_OFS_BYPASS)) begin
                next_bypass = reg_wdata_i[DFCR_BYPASS_BIT];
            end
            if (hit(reg_addr_i, DFCR_OFS_STATUS)) begin
                // Only the two enables take writes; other bits are dropped
                next_cframe_mute_en = reg_wdata_i[DFCR_STS_CFRAME_BIT];
                next_chstat_mute_en = reg_wdata_i[DFCR_STS_CHSTAT_BIT];
            end
            if (hit(reg_addr_i, DFCR_OFS_COEF_L)) begin
                next_coef_low = reg_wdata_i;
            end
            if (hit(reg_addr_i, DFCR_OFS_COEF_H)) begin
                next_coef_addr = reg_wdata_i[15:DFCR_CH_ADDR_LSB];
                next_coef_dir  = reg_wdata_i[DFCR_CH_DIR_BIT];
                next_coef_high = reg_wdata_i[DFCR_CH_VAL_MSB:0];
                next_xfer      = 1'b1;
            end
            // Identification words fall through untouched
        end
    end

    // Control registers
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            eq_mode        <= DFCR_RST_EQ;
            bass_en        <= DFCR_RST_BASS;
            bypass         <= DFCR_RST_BYPASS;
            cframe_mute_en <= DFCR_RST_CFRAME;
            chstat_mute_en <= DFCR_RST_CHSTAT;
            coef_low       <= DFCR_RST_COEF[15:0];
            coef_high      <= DFCR_RST_COEF[19:16];
            coef_addr      <= DFCR_RST_CADDR;
            coef_dir       <= 1'b0;
            xfer           <= 1'b0;
        end else begin
            eq_mode        <= next_eq_mode;
            bass_en        <= next_bass_en;
            bypass         <= next_bypass;
            cframe_mute_en <= next_cframe_mute_en;
            chstat_mute_en <= next_chstat_mute_en;
            coef_low       <= next_coef_low;
            coef_high      <= next_coef_high;
            coef_addr      <= next_coef_addr;
            coef_dir       <= next_coef_dir;
            xfer           <= next_xfer;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    logic [15:0] next_rdata;        // Read word for the addressed register
    logic        next_rvalid;       // Read answer strobe

    // Read mux; unmapped offsets return zero
    always_comb begin
        next_rdata  = reg_rdata_o; // Hold last answer between reads
        next_rvalid = reg_rd_i;
        if (reg_rd_i) begin
            next_rdata = DFCR_RD_ZERO;
            case (reg_addr_i)
                DFCR_OFS_EQ: begin
                    next_rdata[1:0] = eq_mode;
                end
                DFCR_OFS_BASS: begin
                    next_rdata[DFCR_BASS_EN_BIT] = bass_en;
                end
                DFCR_OFS_BYPASS: begin
                    next_rdata[DFCR_BYPASS_BIT] = bypass;
                end
                DFCR_OFS_STATUS: begin
                    // Reserved self-test bits stay zero
                    next_rdata[DFCR_STS_RESAMP_BIT] = unlock_sync[0];
                    next_rdata[DFCR_STS_SPDIF_BIT]  = unlock_sync[1];
                    next_rdata[DFCR_STS_CFRAME_BIT] = cframe_mute_en;
                    next_rdata[DFCR_STS_CHSTAT_BIT] = chstat_mute_en;
                end
                DFCR_OFS_COEF_L: begin
                    next_rdata = coef_low;
                end
                DFCR_OFS_COEF_H: begin
                    next_rdata[15:DFCR_CH_ADDR_LSB]  = coef_addr;
                    next_rdata[DFCR_CH_DIR_BIT]      = coef_dir;
                    next_rdata[DFCR_CH_VAL_MSB:0]    = coef_high;
                end
                DFCR_OFS_VID_0: begin
                    next_rdata = VENDOR_CODE_HI;
                end
                DFCR_OFS_VID_1: begin
                    next_rdata = {VENDOR_CODE_LO, VENDOR_REVISION};
                end
                default: begin
                    next_rdata = DFCR_RD_ZERO;
                end
            endcase
        end
    end

    // Read data register; holds last answer between reads
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_o  <= DFCR_RD_ZERO;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rdata_o  <= next_rdata;
            reg_rvalid_o <= next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Processing controls; bypass masks the EQ, surround and bass enables, not the automute enables
    always_comb begin
        eq_surround_control_enable_o   = ~bypass & (eq_mode != DFCR_RST_EQ);
        surround_eq_select_o = ~bypass & eq_mode[DFCR_EQ_SURROUND_BIT];
        bass_manage_en_o     = ~bypass & bass_en;
        dsp_bypass_o         = bypass;
        compressed_frame_automute_en_o = cframe_mute_en;
        chan_status_automute_en_o      = chstat_mute_en;
        coef_value_o   = {coef_high, coef_low};
        coef_address_o = coef_addr;
        coef_write_o   = coef_dir;
        coef_xfer_o    = xfer;
    end

endmodule

// file: tb/dfcr_regs_properties.sv
// Checker for the feature control register group.
// Assumes it sees only the top module's ports, bound below.
`timescale 1ns/100ps
module dfcr_regs_properties
    import dfcr_pkg::*;
#(
    parameter logic [15:0] VENDOR_CODE_HI  = 16'h1234, // Arbitrary value
    parameter logic [7:0]  VENDOR_CODE_LO  = 8'h56,    // Arbitrary value
    parameter logic [7:0]  VENDOR_REVISION = 8'h01     // Arbitrary value
) (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    // Register port
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [6:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    // Controls
    input wire logic        eq_surround_control_enable_o,
    input wire logic        surround_eq_select_o,
    input wire logic        bass_manage_en_o,
    input wire logic        dsp_bypass_o,
    input wire logic        compressed_frame_automute_en_o,
    input wire logic        chan_status_automute_en_o,
    input wire logic [7:0]  coef_address_o,
    input wire logic        coef_write_o,
    input wire logic        coef_xfer_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    ////////////////////////////////////////////////////////////////////////////
    // Decoded requests
    logic w70, w72, w7a, byp_wr;
    assign w70    = reg_wr_i && reg_addr_i == DFCR_OFS_EQ;
    assign w72    = reg_wr_i && reg_addr_i == DFCR_OFS_BASS;
    assign w7a    = reg_wr_i && reg_addr_i == DFCR_OFS_COEF_H;
    assign byp_wr = reg_wr_i && reg_addr_i == DFCR_OFS_BYPASS;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_eq_mode_write: assert property (w70 && !dsp_bypass_o |=>
        eq_surround_control_enable_o == ($past(reg_wdata_i[1:0]) != 2'h0) &&
        surround_eq_select_o == $past(reg_wdata_i[1])) else $error("eq mode wrong");
    a_surround_with_eq: assert property (surround_eq_select_o |-> eq_surround_control_enable_o)
        else $error("surround without eq");
    a_bass_write: assert property (w72 && !dsp_bypass_o |=>
        bass_manage_en_o == $past(reg_wdata_i[0])) else $error("bass enable wrong");
    a_bypass_gates_all: assert property (dsp_bypass_o |->
        !(eq_surround_control_enable_o || surround_eq_select_o || bass_manage_en_o))
        else $error("bypass not overriding");
    a_bypass_holds: assert property (!byp_wr |=> $stable(dsp_bypass_o))
        else $error("bypass changed without write");
    a_status_fields: assert property (reg_rd_i && reg_addr_i == DFCR_OFS_STATUS |=>
        reg_rdata_o[15:12] == 4'h0 && reg_rdata_o[9:2] == 8'h00 &&
        reg_rdata_o[10] == $past(compressed_frame_automute_en_o) &&
        reg_rdata_o[11] == $past(chan_status_automute_en_o)) else $error("status read wrong");
    a_vendor_upper: assert property (reg_rd_i && reg_addr_i == DFCR_OFS_VID_0 |=>
        reg_rdata_o == VENDOR_CODE_HI) else $error("vendor word wrong");
    a_vendor_revision: assert property (reg_rd_i && reg_addr_i == DFCR_OFS_VID_1 |=>
        reg_rdata_o == {VENDOR_CODE_LO, VENDOR_REVISION}) else $error("revision word wrong");
    a_coef_trigger: assert property (w7a |=> coef_xfer_o &&
        coef_address_o == $past(reg_wdata_i[15:8]) && coef_write_o == $past(reg_wdata_i[7]))
        else $error("coefficient transfer wrong");
    a_xfer_cause: assert property (!w7a |=> !coef_xfer_o)
        else $error("transfer without trigger");

    // Main scenarios
    c_coef_xfer: cover property (w7a);
    c_status_read: cover property (reg_rd_i && reg_addr_i == DFCR_OFS_STATUS);
    c_bypass_on: cover property ($rose(dsp_bypass_o));
endmodule

bind dfcr_regs dfcr_regs_properties #(
    .VENDOR_CODE_HI(VENDOR_CODE_HI), .VENDOR_CODE_LO(VENDOR_CODE_LO),
    .VENDOR_REVISION(VENDOR_REVISION)
) u_props (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .eq_surround_control_enable_o(eq_surround_control_enable_o), .surround_eq_select_o(surround_eq_select_o),
    .bass_manage_en_o(bass_manage_en_o), .dsp_bypass_o(dsp_bypass_o),
    .compressed_frame_automute_en_o(compressed_frame_automute_en_o),
    .chan_status_automute_en_o(chan_status_automute_en_o), .coef_address_o(coef_address_o),
    .coef_write_o(coef_write_o), .coef_xfer_o(coef_xfer_o)
);

// file: tb/dfcr_host_model.sv
// Host controller model driving the register strobes.
// Assumes one request at a time; a read waits for the valid pulse.
`timescale 1ns/100ps
module dfcr_host_model
    import dfcr_pkg::*;
(
    // Clock
    input  wire logic        clk_i,
    // Requests
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic [6:0]       reg_addr_o,
    output logic [15:0]      reg_wdata_o,
    // Answers
    input  wire logic [15:0] reg_rdata_i,
    input  wire logic        reg_rvalid_i
);
    initial begin
        reg_wr_o    <= 1'b0;
        reg_rd_o    <= 1'b0;
        reg_addr_o  <= 7'h00;
        reg_wdata_o <= 16'h0000;
    end
    // One write; idle bus shows inverted values, never stale ones
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_wr_o    <= 1'b1;
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        @(posedge clk_i);
        reg_wr_o    <= 1'b0;
        reg_addr_o  <= ~a;
        reg_wdata_o <= ~d;
    endtask
    // One read with a bounded wait for the answer
    task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic ok);
        @(posedge clk_i);
        reg_rd_o   <= 1'b1;
        reg_addr_o <= a;
        @(posedge clk_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~a;
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk_i);
            ok = (reg_rvalid_i === 1'b1);
            d  = reg_rdata_i;
        end
    endtask
    // Coefficient pair, low word before the trigger word
    task automatic coef(input logic [19:0] v, input logic [7:0] ad, input logic dir);
        wr(DFCR_OFS_COEF_L, v[15:0]);
        wr(DFCR_OFS_COEF_H, {ad, dir, 3'h0, v[19:16]});
    endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the feature control register group.
// Assumes the host model drives the register port.
`timescale 1ns/100ps
module testbench;
    import dfcr_pkg::*;
    localparam logic [15:0] VID_HI  = 16'hA5C3; // Arbitrary value
    localparam logic [7:0]  VID_LO  = 8'h3C;    // Arbitrary value
    localparam logic [7:0]  VID_REV = 8'h7E;    // Arbitrary value
    localparam logic [6:0]  ADDRS [10] = '{7'h70, 7'h72, 7'h74, 7'h76, 7'h78,
        7'h7A, 7'h7C, 7'h7E, 7'h60, 7'h71}; // Mapped plus two unmapped
    logic        clk_i, rst_b_i, wr, rd, rvalid, res_unl, spd_unl, okv;
    logic        eq_on, eq_sur, bass, byp, cf, ch, cw, cx;
    logic [6:0]  addr;
    logic [15:0] wdata, rdata, rdv;
    logic [19:0] cv;
    logic [7:0]  ca;
    int          m_eq, m_bass, m_byp, m_cf, m_ch, m_cl, m_chi; // Reference model
    int          err_total, num_checks, cycles, idx;
    int          seed = 32'h281B79E4;

    dfcr_regs #(.VENDOR_CODE_HI(VID_HI), .VENDOR_CODE_LO(VID_LO), .VENDOR_REVISION(VID_REV))
    DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .resampler_unlock_i(res_unl), .spdif_unlock_i(spd_unl), .eq_surround_control_enable_o(eq_on),
        .surround_eq_select_o(eq_sur), .bass_manage_en_o(bass), .dsp_bypass_o(byp),
        .compressed_frame_automute_en_o(cf), .chan_status_automute_en_o(ch),
        .coef_value_o(cv), .coef_address_o(ca), .coef_write_o(cw), .coef_xfer_o(cx));
    dfcr_host_model host (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparison, expectation and sequence tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] exp_rd(input logic [6:0] a);
        case (a)
            DFCR_OFS_EQ:     return 16'(m_eq);
            DFCR_OFS_BASS:   return 16'(m_bass);
            DFCR_OFS_BYPASS: return 16'(m_byp);
            DFCR_OFS_STATUS: return {4'h0, 1'(m_ch), 1'(m_cf), 8'h00, spd_unl, res_unl};
            DFCR_OFS_COEF_L: return 16'(m_cl);
            DFCR_OFS_COEF_H: return 16'(m_chi);
            DFCR_OFS_VID_0:  return VID_HI;
            DFCR_OFS_VID_1:  return {VID_LO, VID_REV};
            default:         return 16'h0000;
        endcase
    endfunction
    task automatic check_outs();
        check({eq_on, eq_sur, bass, byp, cf, ch}, {!m_byp && m_eq != 0, !m_byp && m_eq > 1,
            !m_byp && m_bass != 0, m_byp != 0, m_cf != 0, m_ch != 0});
        check({cv, ca, cw}, {m_chi[3:0], m_cl[15:0], m_chi[15:8], m_chi[7]});
    endtask
    task automatic do_wr(input logic [6:0] a, input logic [15:0] d);
        host.wr(a, d);
        #1;
        case (a)
            DFCR_OFS_EQ:     m_eq = d & 16'h0003;
            DFCR_OFS_BASS:   m_bass = d & 16'h0001;
            DFCR_OFS_BYPASS: m_byp = d & 16'h0001;
            DFCR_OFS_STATUS: {m_ch, m_cf} = {31'h0, d[11], 31'h0, d[10]};
            DFCR_OFS_COEF_L: m_cl = d;
            DFCR_OFS_COEF_H: m_chi = d & 16'hFF8F;
            default:         ;
        endcase
        check(cx, a == DFCR_OFS_COEF_H);
        check_outs();
    endtask
    task automatic do_rd(input logic [6:0] a);
        logic [15:0] d;
        logic        ok;
        host.rd(a, d, ok);
        check(ok, 1'b1);
        check(d, exp_rd(a));
    endtask
    task automatic do_reset();
        rst_b_i <= 1'b0;
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        {m_eq, m_bass, m_byp, m_ch, m_cl, m_chi} = '0;
        m_cf = 1;
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, modes, coefficients, random traffic, reset again
    initial begin
        res_unl <= 1'b1;
        spd_unl <= 1'b1;
        do_reset();
        foreach (ADDRS[i]) do_rd(ADDRS[i]);
        for (int i = 0; i < 8; i++) begin
            do_wr(DFCR_OFS_BYPASS, 16'(i / 4));
            do_wr(DFCR_OFS_EQ, 16'(i % 4));
            do_wr(DFCR_OFS_BASS, 16'hFFFF);
        end
        host.coef(20'hABCDE, 8'h5A, 1'b1);
        #1;
        {m_cl, m_chi} = {32'h0000BCDE, 32'h00005A8A};
        check(cx, 1'b1);
        check_outs();
        repeat (60) begin
            res_unl <= 1'($random(seed));
            spd_unl <= 1'($random(seed));
            idx = $unsigned($random(seed)) % 10;
            do_wr(ADDRS[idx], 16'($random(seed)));
            idx = $unsigned($random(seed)) % 10;
            do_rd(ADDRS[idx]);
        end
        // Loops report locked, yet status must still read unlocked just after reset
        res_unl <= 1'b0;
        spd_unl <= 1'b0;
        do_reset();
        host.rd(DFCR_OFS_STATUS, rdv, okv);
        check({okv, rdv}, {1'b1, 16'h0403});
        foreach (ADDRS[i]) do_rd(ADDRS[i]);
        complete_run();
    end
endmodule
